/* File: bench/dspc_master_model.sv */
// bus master model: sends command telegrams and takes the replies
`timescale 1ns/1ps
module dspc_master_model import dspc_pkg::*; #(
    parameter logic [7:0] ADDR = 8'h01
) (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] reply[$];
    int stall = 0;
    // idle link at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_end = 1'b0;
        tx_ready = 1'b0;
    end
    // one whole telegram out, then n reply bytes in; stall slows the taking of each byte
    task automatic xfer(input logic [7:0] cmd[$], input int n);
        logic [7:0] t[$];
        logic [7:0] x;
        int w;
        t = {ADDR, cmd};
        x = 8'h00;
        foreach (t[i]) x = x ^ t[i];
        t.push_back(x);
        for (int i = 0; i < t.size(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= t[i];
            rx_end <= (i == t.size() - 1);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_end <= 1'b0;
        rx_data <= ~t[t.size() - 1]; // a released line must not repeat the last byte
        reply = {};
        for (int k = 0; k < n; k++) begin
            w = 0;
            @(negedge clk);
            while (tx_valid !== 1'b1 && w < 50) begin
                @(negedge clk);
                w++;
            end
            repeat (stall) @(negedge clk);
            reply.push_back(tx_data);
            @(posedge clk);
            tx_ready <= 1'b1;
            @(posedge clk);
            tx_ready <= 1'b0;
        end
    endtask
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the drive serial parameter command block
`timescale 1ns/1ps
module tb_top import dspc_pkg::*;;
    logic clk, rst, rx_valid, rx_end, tx_valid, tx_ready, ext_reset_cmd, reg_wr, reg_rd;
    logic [7:0] rx_data, tx_data, dev_error_high, reg_addr;
    logic [15:0] act_baud_code, act_tmo_code;
    logic stop_drive, restore_pulse, rot_clear_pulse, nv_save;
    logic [31:0] reg_wdata, reg_rdata;
    int miscompares = 0, checks = 0, n_rst = 0, n_nv = 0, n0;
    logic [15:0] bd[7] = '{16'h2580, 16'h4B00, 16'h9600, 16'h1234, 16'h9600, 16'h9600, 16'h4B00};
    logic [15:0] tm[7] = '{16'h0014, 16'h00C8, 16'h0014, 16'h0014, 16'h0013, 16'h00C9, 16'h0064};
    logic [7:0] er[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

    dspc_top #(.WDG_STEP_CYCLES(4)) DUT (.clk, .rst, .rx_valid, .rx_data, .rx_end, .tx_valid, .tx_data,
        .tx_ready, .ext_reset_cmd, .act_baud_code, .act_tmo_code, .dev_error_high, .stop_drive,
        .restore_pulse, .rot_clear_pulse, .nv_save, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    dspc_master_model mst (.clk, .rx_valid, .rx_data, .rx_end, .tx_valid, .tx_data, .tx_ready);

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // pulse counters; restore and rotation clear must come together
    always @(posedge clk) begin
        if (restore_pulse === 1'b1 && rot_clear_pulse === 1'b1) n_rst <= n_rst + 1;
        if (nv_save === 1'b1) n_nv <= n_nv + 1;
    end
    // hang guard, far above the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // one telegram; the whole reply is compared, address and own xor included
    task automatic tg(input logic [7:0] cmd[$], input logic [7:0] exp[$]);
        logic [7:0] e[$];
        logic [7:0] x;
        e = {8'h01, exp};
        x = 8'h00;
        foreach (e[i]) x = x ^ e[i];
        e.push_back(x);
        mst.xfer(cmd, e.size());
        @(negedge clk);
        check(tx_valid, 1'b0);
        foreach (e[i]) check(mst.reply[i], e[i]);
    endtask

    // main sequence
    initial begin
        {rst, ext_reset_cmd, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 43'h0};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(REG_ACT, 32'h96000014);
        rd(REG_SER, 32'h96000014);
        rd(REG_WDG, 32'h00000014);
        rd(8'h40, 32'h00000000);
        tg({8'h81, 8'h22, 8'h00, 8'h0A, 8'h00, 8'hFF}, {8'h81, 8'h00, 8'h00});
        $display("defaults done");
        n0 = n_nv;
        tg({8'h81, 8'h24, 8'h00, 8'h07, 8'h25, 8'h80, 8'h00, 8'h14}, {8'h81, 8'h00, 8'h00});
        check(n_nv - n0, 1);
        rd(REG_ACT, 32'h96000014);
        @(posedge clk);
        ext_reset_cmd <= 1'b1;
        @(posedge clk);
        ext_reset_cmd <= 1'b0;
        rd(REG_ACT, 32'h25800014);
        check({act_baud_code, act_tmo_code}, 32'h25800014);
        mst.stall = 3;
        tg({8'h82, 8'h24, 8'h00, 8'h07}, {8'h82, 8'h00, 8'h00});
        tg({8'h83}, {8'h83, 8'h00, 8'h00, 8'h24, 8'h25, 8'h80, 8'h00, 8'h14});
        mst.stall = 0;
        $display("serial write and read done");
        for (int i = 0; i < 7; i++) begin
            tg({8'h81, 8'h24, 8'h00, 8'h07, bd[i][15:8], bd[i][7:0], tm[i][15:8], tm[i][7:0]},
                {8'h81, 8'h00, er[i]});
        end
        rd(REG_SER, 32'h4B000064);
        rd(REG_ACT, 32'h25800014);
        $display("serial ranges done");
        tg({8'h82, 8'h22, 8'h00, 8'h0A}, {8'h82, 8'h00, 8'h00});
        tg({8'h83}, {8'h83, 8'h00, 8'h00, 8'h22, 8'h00, 8'hFF});
        tg({8'h81, 8'h22, 8'h00, 8'h0A, 8'h00, 8'h00}, {8'h81, 8'h00, 8'h01});
        tg({8'h81, 8'h22, 8'h00, 8'h0A, 8'h00, 8'h65}, {8'h81, 8'h00, 8'h01});
        tg({8'h81, 8'h22, 8'h00, 8'h0A, 8'h00, 8'h01}, {8'h81, 8'h00, 8'h00});
        repeat (12) @(posedge clk);
        check({stop_drive, dev_error_high}, 9'h180);
        tg({8'h81, 8'h22, 8'h00, 8'h0A, 8'h00, 8'hFF}, {8'h81, 8'h00, 8'h00});
        check({stop_drive, dev_error_high}, 9'h180);
        rd(REG_STAT, 32'h00000080);
        wr(REG_CTRL, 32'h00000001);
        repeat (2) @(posedge clk);
        check({stop_drive, dev_error_high}, 9'h000);
        check({act_baud_code, act_tmo_code}, 32'h4B000064);
        $display("watchdog done");
        tg({8'h81, 8'h22, 8'h00, 8'h0A, 8'h00, 8'h64}, {8'h81, 8'h00, 8'h00});
        n0 = n_rst;
        tg({8'h81, 8'h24, 8'h00, 8'h09, 8'hAA, 8'hCC, 8'h11, 8'h55}, {8'h81, 8'h00, 8'h00});
        check(n_rst - n0, 1);
        rd(REG_WDG, 32'h00000014);
        $display("restore done");
        summarize();
    end
endmodule

/* File: core/dspc_pkg.sv */
// shared constants, types and helpers of the drive serial parameter command block
package dspc_pkg;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int WDG_STEP_MS = 100;
    localparam int WDG_STEP_CYC = CLK_HZ / 1000 * WDG_STEP_MS;
    localparam int TMO_SCALE = 10;
    // line rate codes and accept timeout codes
    localparam logic [15:0] BAUD_9600 = 16'h2580;
    localparam logic [15:0] BAUD_19200 = 16'h4B00;
    localparam logic [15:0] BAUD_38400 = 16'h9600;
    localparam logic [15:0] TMO_MIN = 16'h0014;
    localparam logic [15:0] TMO_MAX = 16'h00C8;
    localparam logic [15:0] TMO_DEF = 16'h0014;
    // watchdog period codes
    localparam logic [7:0] WDG_DEF = 8'h14;
    localparam logic [7:0] WDG_MIN = 8'h01;
    localparam logic [7:0] WDG_MAX = 8'h64;
    localparam logic [7:0] WDG_OFF = 8'hFF;
    localparam int FAULT_BIT = 7;
    // telegram bytes
    localparam logic [7:0] OP_WRITE = 8'h81;
    localparam logic [7:0] OP_SELECT = 8'h82;
    localparam logic [7:0] OP_FETCH = 8'h83;
    localparam logic [7:0] GRP_24 = 8'h24;
    localparam logic [7:0] GRP_22 = 8'h22;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] IDX_SER = 8'h07;
    localparam logic [7:0] IDX_WDG = 8'h0A;
    localparam logic [7:0] IDX_RESTORE = 8'h09;
    localparam logic [31:0] RESTORE_KEY = 32'hAACC1155;
    // telegram lengths, address and checksum included
    localparam logic [3:0] LEN_SER_WR = 4'hA;
    localparam logic [3:0] LEN_RESTORE = 4'hA;
    localparam logic [3:0] LEN_WDG_WR = 4'h8;
    localparam logic [3:0] LEN_SELECT = 4'h6;
    localparam logic [3:0] LEN_FETCH = 4'h3;
    localparam logic [3:0] LEN_ACK = 4'h5;
    localparam logic [3:0] LEN_SER_RD = 4'hA;
    localparam logic [3:0] LEN_WDG_RD = 4'h8;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_VALUE = 16'h0001;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_SER = 8'h08;
    localparam logic [7:0] REG_WDG = 8'h0C;
    localparam logic [7:0] REG_ACT = 8'h10;
    localparam int CTRL_RESET_BIT = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam int BUF_DEPTH = 10;

    typedef logic [7:0] dspc_buf_t [BUF_DEPTH];
    typedef enum {DSPC_COLLECT, DSPC_DECODE, DSPC_SEND} dspc_state_t;
    typedef enum {DSPC_SEL_NONE, DSPC_SEL_SER, DSPC_SEL_WDG} dspc_sel_t;

    // xor of the first n bytes
    function automatic logic [7:0] dspc_xor(input dspc_buf_t b, input logic [3:0] n);
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (4'(i) < n) begin
                x = x ^ b[i];
            end
        end
        return x;
    endfunction

    function automatic logic dspc_baud_ok(input logic [15:0] v);
        return (v == BAUD_9600) || (v == BAUD_19200) || (v == BAUD_38400);
    endfunction

    function automatic logic dspc_tmo_ok(input logic [15:0] v);
        return (v >= TMO_MIN) && (v <= TMO_MAX);
    endfunction

    function automatic logic dspc_wdg_ok(input logic [7:0] v);
        return ((v >= WDG_MIN) && (v <= WDG_MAX)) || (v == WDG_OFF);
    endfunction
endpackage

/* File: core/dspc_top.sv */
// telegram interpreter for serial settings, watchdog period and restore defaults
`timescale 1ns/1ps
// Functional notes
// - serial settings default 38400 baud, 2.0 ms
// - line rate only 9600, 19200 or 38400
// - timeout code ms times ten, 2..20 ms
// - new serial settings active only after reset
// - serial write: code, rate, timeout; saved nonvolatile
// - serial read: select, acknowledge, then fetch reply
// - watchdog period defaults to 2000 ms
// - silent master: set fault bit 7, stop
// - watchdog fault held until reset command
// - period codes 1..100 of 100 ms; FF disables
// - watchdog write: five code bytes, one value
// - watchdog read: select then fetch with group bytes
// - restore defaults: offset, limits, watchdog period
// - restore clears rotation count of position
module dspc_top import dspc_pkg::*; #(
    parameter logic [7:0] DEV_ADDR = 8'h01,
    parameter int WDG_STEP_CYCLES = WDG_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic ext_reset_cmd,
    output logic [15:0] act_baud_code,
    output logic [15:0] act_tmo_code,
    output logic [7:0] dev_error_high,
    output logic stop_drive,
    output logic restore_pulse,
    output logic rot_clear_pulse,
    output logic nv_save,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    initial begin
        if (WDG_STEP_CYCLES < 1) begin
            $error("watchdog step must be at least one cycle");
        end
    end

    dspc_wdg_if w ();

    dspc_state_t state_reg, state_next;
    dspc_sel_t sel_reg, sel_next;
    dspc_buf_t rx_buf_reg, rx_buf_next;
    dspc_buf_t tx_buf_reg, tx_buf_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] tx_left_reg, tx_left_next;
    logic ovf_reg, ovf_next;
    logic [15:0] ser_baud_reg, ser_baud_next;
    logic [15:0] ser_tmo_reg, ser_tmo_next;
    logic [15:0] act_baud_reg, act_baud_next;
    logic [15:0] act_tmo_reg, act_tmo_next;
    logic [7:0] wdg_period_reg, wdg_period_next;
    logic restore_reg, restore_next;
    logic nv_save_reg, nv_save_next;
    logic kick_reg, kick_next;
    logic [31:0] rdata_reg, rdata_next;
    logic reset_evt;
    logic [15:0] err;
    logic [3:0] len;
    logic frame_ok;

    // reset command from the drive's decoder or from software
    assign reset_evt = ext_reset_cmd || (reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_RESET_BIT]);

    // telegram collection, decode and reply
    always_comb begin
        state_next = state_reg;
        sel_next = sel_reg;
        rx_buf_next = rx_buf_reg;
        tx_buf_next = tx_buf_reg;
        cnt_next = cnt_reg;
        tx_left_next = tx_left_reg;
        ovf_next = ovf_reg;
        ser_baud_next = ser_baud_reg;
        ser_tmo_next = ser_tmo_reg;
        wdg_period_next = wdg_period_reg;
        restore_next = 1'b0;
        nv_save_next = 1'b0;
        kick_next = 1'b0;
        err = ERR_NONE;
        len = 4'h0;
        frame_ok = 1'b0;
        case (state_reg)
            DSPC_COLLECT: begin
                // overlong telegrams are marked and dropped whole
                if (rx_valid) begin
                    if (cnt_reg < 4'(BUF_DEPTH)) begin
                        rx_buf_next[cnt_reg] = rx_data;
                        cnt_next = cnt_reg + 4'h1;
                    end else begin
                        ovf_next = 1'b1;
                    end
                end
                if (rx_end) begin
                    state_next = DSPC_DECODE;
                end
            end
            DSPC_DECODE: begin
                frame_ok = !ovf_reg && (cnt_reg >= LEN_FETCH) && (rx_buf_reg[0] == DEV_ADDR)
                    && (dspc_xor(rx_buf_reg, cnt_reg) == 8'h00);
                for (int i = 0; i < BUF_DEPTH; i++) begin
                    tx_buf_next[i] = 8'h00;
                end
                if (frame_ok) begin
                    kick_next = 1'b1;
                    if ((cnt_reg == LEN_SER_WR) && ({rx_buf_reg[1], rx_buf_reg[2], rx_buf_reg[3], rx_buf_reg[4]}
                        == {OP_WRITE, GRP_24, BYTE_ZERO, IDX_SER})) begin
                        // bad values are refused with a nonzero error word
                        if (dspc_baud_ok({rx_buf_reg[5], rx_buf_reg[6]})
                            && dspc_tmo_ok({rx_buf_reg[7], rx_buf_reg[8]})) begin
                            ser_baud_next = {rx_buf_reg[5], rx_buf_reg[6]};
                            ser_tmo_next = {rx_buf_reg[7], rx_buf_reg[8]};
                            nv_save_next = 1'b1;
                        end else begin
                            err = ERR_VALUE;
                        end
                        len = LEN_ACK;
                    end else if ((cnt_reg == LEN_RESTORE) && ({rx_buf_reg[1], rx_buf_reg[2], rx_buf_reg[3],
                        rx_buf_reg[4]} == {OP_WRITE, GRP_24, BYTE_ZERO, IDX_RESTORE}) && ({rx_buf_reg[5],
                        rx_buf_reg[6], rx_buf_reg[7], rx_buf_reg[8]} == RESTORE_KEY)) begin
                        wdg_period_next = WDG_DEF;
                        restore_next = 1'b1;
                        nv_save_next = 1'b1;
                        len = LEN_ACK;
                    end else if ((cnt_reg == LEN_WDG_WR) && ({rx_buf_reg[1], rx_buf_reg[2], rx_buf_reg[3],
                        rx_buf_reg[4], rx_buf_reg[5]} == {OP_WRITE, GRP_22, BYTE_ZERO, IDX_WDG, BYTE_ZERO})) begin
                        if (dspc_wdg_ok(rx_buf_reg[6])) begin
                            wdg_period_next = rx_buf_reg[6];
                            nv_save_next = 1'b1;
                        end else begin
                            err = ERR_VALUE;
                        end
                        len = LEN_ACK;
                    end else if ((cnt_reg == LEN_SELECT) && (rx_buf_reg[1] == OP_SELECT)) begin
                        if ({rx_buf_reg[2], rx_buf_reg[3], rx_buf_reg[4]} == {GRP_24, BYTE_ZERO, IDX_SER}) begin
                            sel_next = DSPC_SEL_SER;
                            len = LEN_ACK;
                        end else if ({rx_buf_reg[2], rx_buf_reg[3], rx_buf_reg[4]}
                            == {GRP_22, BYTE_ZERO, IDX_WDG}) begin
                            sel_next = DSPC_SEL_WDG;
                            len = LEN_ACK;
                        end
                    end else if ((cnt_reg == LEN_FETCH) && (rx_buf_reg[1] == OP_FETCH)) begin
                        tx_buf_next[0] = DEV_ADDR;
                        tx_buf_next[1] = OP_FETCH;
                        if (sel_reg == DSPC_SEL_SER) begin
                            tx_buf_next[4] = GRP_24;
                            tx_buf_next[5] = ser_baud_reg[15:8];
                            tx_buf_next[6] = ser_baud_reg[7:0];
                            tx_buf_next[7] = ser_tmo_reg[15:8];
                            tx_buf_next[8] = ser_tmo_reg[7:0];
                            len = LEN_SER_RD;
                        end else if (sel_reg == DSPC_SEL_WDG) begin
                            tx_buf_next[4] = GRP_22;
                            tx_buf_next[5] = BYTE_ZERO;
                            tx_buf_next[6] = wdg_period_reg;
                            len = LEN_WDG_RD;
                        end
                    end
                    // acknowledge carries the echoed command byte and error word
                    if (len == LEN_ACK) begin
                        tx_buf_next[0] = DEV_ADDR;
                        tx_buf_next[1] = rx_buf_reg[1];
                        tx_buf_next[2] = err[15:8];
                        tx_buf_next[3] = err[7:0];
                    end
                end
                // unused slots are zero, so an xor over the first len bytes gives the checksum
                if (len != 4'h0) begin
                    tx_buf_next[len - 4'h1] = dspc_xor(tx_buf_next, len);
                    state_next = DSPC_SEND;
                end else begin
                    state_next = DSPC_COLLECT;
                end
                tx_left_next = len;
                cnt_next = 4'h0;
                ovf_next = 1'b0;
            end
            DSPC_SEND: begin
                // half duplex: receive bytes are ignored while replying
                if (tx_ready) begin
                    for (int i = 0; i < BUF_DEPTH - 1; i++) begin
                        tx_buf_next[i] = tx_buf_reg[i + 1];
                    end
                    tx_buf_next[BUF_DEPTH - 1] = 8'h00;
                    tx_left_next = tx_left_reg - 4'h1;
                    if (tx_left_reg == 4'h1) begin
                        state_next = DSPC_COLLECT;
                    end
                end
            end
            default: begin
                state_next = DSPC_COLLECT;
            end
        endcase
    end

    // stored settings reach the link only on a reset command
    always_comb begin
        act_baud_next = reset_evt ? ser_baud_reg : act_baud_reg;
        act_tmo_next = reset_evt ? ser_tmo_reg : act_tmo_reg;
    end

    // register read port, data valid only in the cycle after the strobe
    always_comb begin
        rdata_next = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                REG_STAT: begin
                    rdata_next[7:0] = dev_error_high;
                    rdata_next[STAT_BUSY_BIT] = (state_reg != DSPC_COLLECT);
                end
                REG_SER: rdata_next = {ser_baud_reg, ser_tmo_reg};
                REG_WDG: rdata_next[7:0] = wdg_period_reg;
                REG_ACT: rdata_next = {act_baud_reg, act_tmo_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= DSPC_COLLECT;
            sel_reg <= DSPC_SEL_NONE;
            rx_buf_reg <= '{default: 8'h00};
            tx_buf_reg <= '{default: 8'h00};
            cnt_reg <= 4'h0;
            tx_left_reg <= 4'h0;
            ovf_reg <= 1'b0;
            ser_baud_reg <= BAUD_38400;
            ser_tmo_reg <= TMO_DEF;
            act_baud_reg <= BAUD_38400;
            act_tmo_reg <= TMO_DEF;
            wdg_period_reg <= WDG_DEF;
            restore_reg <= 1'b0;
            nv_save_reg <= 1'b0;
            kick_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            rx_buf_reg <= rx_buf_next;
            tx_buf_reg <= tx_buf_next;
            cnt_reg <= cnt_next;
            tx_left_reg <= tx_left_next;
            ovf_reg <= ovf_next;
            ser_baud_reg <= ser_baud_next;
            ser_tmo_reg <= ser_tmo_next;
            act_baud_reg <= act_baud_next;
            act_tmo_reg <= act_tmo_next;
            wdg_period_reg <= wdg_period_next;
            restore_reg <= restore_next;
            nv_save_reg <= nv_save_next;
            kick_reg <= kick_next;
            rdata_reg <= rdata_next;
        end
    end

    // watchdog hookup; a period write also restarts it through the kick
    assign w.period = wdg_period_reg;
    assign w.kick = kick_reg;
    assign w.clear = reset_evt;

    dspc_wdog #(.STEP_CYCLES(WDG_STEP_CYCLES)) u_wdog (
        .clk(clk),
        .rst(rst),
        .w(w)
    );

    // outputs
    always_comb begin
        dev_error_high = 8'h00;
        dev_error_high[FAULT_BIT] = w.fault;
    end
    assign stop_drive = w.fault;
    assign tx_valid = (state_reg == DSPC_SEND);
    assign tx_data = tx_buf_reg[0];
    assign act_baud_code = act_baud_reg;
    assign act_tmo_code = act_tmo_reg;
    assign restore_pulse = restore_reg;
    assign rot_clear_pulse = restore_reg;
    assign nv_save = nv_save_reg;
    assign reg_rdata = rdata_reg;

    property p_act_hold;
        @(posedge clk) disable iff (rst) !reset_evt |=> $stable(act_baud_reg) && $stable(act_tmo_reg);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("active settings changed without reset");

    property p_act_load;
        @(posedge clk) disable iff (rst) reset_evt |=> act_baud_reg == $past(ser_baud_reg);
    endproperty
    a_act_load: assert property (p_act_load) else $error("reset did not load stored line rate");

    property p_baud_ok;
        @(posedge clk) disable iff (rst) dspc_baud_ok(ser_baud_reg) && dspc_baud_ok(act_baud_reg);
    endproperty
    a_baud_ok: assert property (p_baud_ok) else $error("illegal line rate code held");

    property p_tmo_ok;
        @(posedge clk) disable iff (rst) dspc_tmo_ok(ser_tmo_reg) && dspc_tmo_ok(act_tmo_reg);
    endproperty
    a_tmo_ok: assert property (p_tmo_ok) else $error("timeout code out of range");

    property p_wdg_ok;
        @(posedge clk) disable iff (rst) dspc_wdg_ok(wdg_period_reg);
    endproperty
    a_wdg_ok: assert property (p_wdg_ok) else $error("illegal watchdog period held");

    property p_restore;
        @(posedge clk) disable iff (rst) restore_pulse
            |-> rot_clear_pulse && (wdg_period_reg == WDG_DEF) ##1 !restore_pulse;
    endproperty
    a_restore: assert property (p_restore) else $error("restore did not reset period");

    property p_reply_head;
        @(posedge clk) disable iff (rst) (state_reg == DSPC_DECODE) && (state_next == DSPC_SEND)
            |=> tx_valid && (tx_data == DEV_ADDR) && (tx_left_reg >= LEN_ACK);
    endproperty
    a_reply_head: assert property (p_reply_head) else $error("reply does not start with address");

    property p_save;
        @(posedge clk) disable iff (rst) nv_save && !restore_pulse
            |-> kick_reg && (rx_buf_reg[1] == OP_WRITE) && ({tx_buf_reg[2], tx_buf_reg[3]} == ERR_NONE);
    endproperty
    a_save: assert property (p_save) else $error("save pulse outside a write");
endmodule

/* File: core/dspc_wdg_if.sv */
// carrier between command core and telegram watchdog
`timescale 1ns/1ps
interface dspc_wdg_if;
    logic [7:0] period;
    logic kick;
    logic clear;
    logic fault;
    modport core (output period, output kick, output clear, input fault);
    modport timer (input period, input kick, input clear, output fault);
endinterface

/* File: core/dspc_wdog.sv */
// telegram watchdog timer with sticky fault
`timescale 1ns/1ps
module dspc_wdog import dspc_pkg::*; #(
    parameter int STEP_CYCLES = WDG_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    dspc_wdg_if.timer w
);
    initial begin
        if (STEP_CYCLES < 1) begin
            $error("watchdog step must be at least one cycle");
        end
    end

    logic [31:0] pre_reg, pre_next;
    logic [7:0] steps_reg, steps_next;
    logic fault_reg, fault_next;
    logic tick, set;

    // prescaler to 100 ms steps, then step count against the period code
    always_comb begin
        tick = (pre_reg == 32'(STEP_CYCLES - 1));
        set = tick && !w.kick && !fault_reg && (w.period != WDG_OFF) && ((steps_reg + 8'h01) == w.period);
        pre_next = tick ? 32'h00000000 : pre_reg + 32'h00000001;
        steps_next = tick ? steps_reg + 8'h01 : steps_reg;
        // frozen while disabled or faulted, restarted by any valid telegram to this device or a reset
        if (w.kick || w.clear || fault_reg || (w.period == WDG_OFF)) begin
            pre_next = 32'h00000000;
            steps_next = 8'h00;
        end
        // a fault arriving with the clear is kept
        fault_next = set || (fault_reg && !w.clear);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_reg <= 32'h00000000;
            steps_reg <= 8'h00;
            fault_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            steps_reg <= steps_next;
            fault_reg <= fault_next;
        end
    end

    assign w.fault = fault_reg;

    property p_sticky;
        @(posedge clk) disable iff (rst) fault_reg && !w.clear |=> fault_reg;
    endproperty
    a_sticky: assert property (p_sticky) else $error("watchdog fault dropped without reset");

    property p_off;
        @(posedge clk) disable iff (rst) !fault_reg && (w.period == WDG_OFF) |=> !fault_reg;
    endproperty
    a_off: assert property (p_off) else $error("disabled watchdog raised fault");

    property p_kick;
        @(posedge clk) disable iff (rst) w.kick && !fault_reg |=> !fault_reg && (steps_reg == 8'h00);
    endproperty
    a_kick: assert property (p_kick) else $error("telegram did not restart watchdog");
endmodule
